// >>> dv/spi_busy_slave_model.sv
// behavioural spi slave that paces the master with a busy ready line
`timescale 1ns/1ns
module spi_busy_slave_model (
    input wire logic link_clock_i, // paces the busy delay
    input wire logic sel_a_n_i, // first select, active low
    input wire logic sel_b_n_i, // second select, active low
    input wire logic sck_i, // serial clock from master
    input wire logic mosi_i, // data from master
    input wire logic [15:0] delay_i, // link clocks until ready, ffff waits 65535 link clocks
    input wire logic [7:0] status_i, // status answer
    input wire logic [7:0] data_i, // data character sent
    output logic busy_o, // low when ready
    output logic miso_o, // data to master
    output logic [7:0] first_o, // command of this selection
    output logic [7:0] last_o, // last byte received
    output logic [7:0] n_got_o, // bytes received this selection
    output logic [7:0] early_o // sck falls seen while busy high
);
    logic sel_n;
    logic [2:0] nbit = 3'h0;
    logic [7:0] rx_sh = 8'h00;
    logic [7:0] tx_sh = 8'hff;
    logic miso_q = 1'b1;
    logic kick = 1'b0;
    logic kick_q = 1'b0;
    logic [15:0] cnt = 16'h0000;
    assign sel_n = sel_a_n_i & sel_b_n_i;
    // a released line shows the inverse, so a stale bit never passes
    assign miso_o = sel_n ? ~miso_q : miso_q;
    // busy rises with the last clock of a character, so the master never sees a stale low
    assign busy_o = sel_n | (kick != kick_q) | (cnt < delay_i);
    always @(negedge sel_n)
    begin
        nbit = 3'h0;
        n_got_o = 8'h00;
        early_o = 8'h00;
        tx_sh = 8'hff;
        kick = ~kick;
    end
    always @(negedge sck_i)
    begin
        if (!sel_n)
        begin
            if (busy_o)
                early_o = early_o + 8'h01;
            miso_q = tx_sh[7];
            tx_sh = {tx_sh[6:0], 1'b1};
        end
    end
    always @(posedge sck_i)
    begin
        if (!sel_n)
        begin
            rx_sh = {rx_sh[6:0], mosi_i};
            nbit = nbit + 3'h1;
            if (nbit == 3'h0)
            begin
                if (n_got_o == 8'h00)
                    first_o = rx_sh;
                last_o = rx_sh;
                tx_sh = (first_o == 8'h00) ? status_i : data_i;
                n_got_o = n_got_o + 8'h01;
                kick = ~kick;
            end
        end
    end
    // busy goes high again after every character and at selection
    always @(posedge link_clock_i)
    begin
        if (sel_n || kick != kick_q)
        begin
            cnt <= 16'h0000;
            kick_q <= kick;
        end
        else if (cnt != 16'hffff)
            cnt <= cnt + 16'h0001;
    end
endmodule

// >>> dv/spi_master_busy_handshake_test.sv
// self-checking bench for the busy-handshake spi master
`timescale 1ns/1ns
`define CHECK(got, exp) \
    begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module spi_master_busy_handshake_test;
    localparam int SLOT = 2400;
    logic clock_i, link_clock_i, reset_n_i, busy, miso, sel_a_n, sel_b_n, sck, mosi;
    logic tx_take, rx_valid, active_slave, timeout, slot_done, refused;
    logic [7:0] rx_byte, slave_status, first, last, n_got, early;
    logic [1:0] op_mode = 2'h3;
    logic [5:0] char_count = 6'h02;
    logic [5:0] sck_half = 6'h06;
    logic busy_sync_en = 1'b1;
    logic timeout_en = 1'b1;
    logic [7:0] tx_byte = 8'h31;
    logic [15:0] delay = 16'h000a;
    logic [7:0] status = 8'h48;
    logic [7:0] data = 8'h96;
    int n_fail = 0, n_tests = 0, cyc = 0, c_done = 0, c_to = 0, c_ref = 0, c_rxv = 0;
    int c_take = 0, t_to = 0, t_rise, s_done, s_to, s_ref, s_rxv, s_take, who, t0, t1;

    spi_master_busy_handshake #(.SLOT_CYCLES(SLOT)) u_dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .link_clock_i(link_clock_i),
        .busy_i(busy), .master_serial_data_in_i(miso),
        .first_slave_select_n_o(sel_a_n), .second_slave_select_n_o(sel_b_n),
        .master_serial_clock_out_o(sck), .master_serial_data_out_o(mosi),
        .op_mode_i(op_mode), .char_count_i(char_count), .sck_half_i(sck_half),
        .busy_sync_en_i(busy_sync_en), .timeout_en_i(timeout_en),
        .tx_byte_i(tx_byte), .tx_take_o(tx_take), .rx_byte_o(rx_byte),
        .rx_valid_o(rx_valid), .slave_status_o(slave_status),
        .active_slave_o(active_slave), .timeout_o(timeout), .slot_done_o(slot_done),
        .refused_o(refused));
    spi_busy_slave_model u_slave (
        .link_clock_i(link_clock_i), .sel_a_n_i(sel_a_n), .sel_b_n_i(sel_b_n),
        .sck_i(sck), .mosi_i(mosi), .delay_i(delay), .status_i(status), .data_i(data),
        .busy_o(busy), .miso_o(miso), .first_o(first), .last_o(last),
        .n_got_o(n_got), .early_o(early));

    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    // link clock free-running, phase unrelated to the system clock
    initial
    begin
        link_clock_i = 1'b0;
        #17;
        forever #40 link_clock_i = ~link_clock_i;
    end
    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (tx_take === 1'b1) tx_byte <= tx_byte + 8'h01;
        if (tx_take === 1'b1) c_take <= c_take + 1;
        if (rx_valid === 1'b1) c_rxv <= c_rxv + 1;
        if (slot_done === 1'b1) c_done <= c_done + 1;
        if (refused === 1'b1) c_ref <= c_ref + 1;
        if (timeout === 1'b1) c_to <= c_to + 1;
        if (timeout === 1'b1) t_to <= cyc;
    end

    task automatic end_sim();
        begin
            $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task automatic hang();
        begin
            n_fail++;
            $display("Error at %0t: wait ran out", $time);
            end_sim();
        end
    endtask
    task automatic cfg(input logic [1:0] m, input logic [5:0] c, input logic [5:0] h,
        input logic s, input logic t, input logic [15:0] d, input logic [7:0] a);
        begin
            @(posedge clock_i);
            op_mode <= m;
            char_count <= c;
            sck_half <= h;
            busy_sync_en <= s;
            timeout_en <= t;
            delay <= d;
            status <= a;
        end
    endtask
    // waits one whole selection; t_fall is the edge index of the select fall
    task automatic run_slot(output int sel_who, output int t_fall);
        int n;
        begin
            {s_done, s_to, s_ref, s_rxv, s_take} = {c_done, c_to, c_ref, c_rxv, c_take};
            n = 0;
            while (sel_a_n & sel_b_n)
            begin
                @(posedge clock_i);
                #1;
                n++;
                if (n > 3 * SLOT) hang();
            end
            sel_who = sel_a_n ? 1 : 0;
            t_fall = cyc - 1;
            n = 0;
            while (!(sel_a_n & sel_b_n))
            begin
                @(posedge clock_i);
                #1;
                n++;
                if (n > 3 * SLOT) hang();
            end
            t_rise = cyc - 1;
            repeat (3) @(posedge clock_i);
            #1;
        end
    endtask

    task automatic pair_txrx();
        begin
            run_slot(who, t0);
            `CHECK(who, 0)
            `CHECK(first, 8'h00)
            `CHECK(slave_status, 8'h48)
            `CHECK(early, 8'h00)
            `CHECK(c_done - s_done, 1)
            run_slot(who, t1);
            `CHECK(t1 - t0, SLOT)
            `CHECK(first, 8'hc2)
            `CHECK(n_got, 8'h03)
            `CHECK(last, 8'h32)
            `CHECK(rx_byte, 8'h96)
            `CHECK(c_rxv - s_rxv, 2)
            `CHECK(active_slave, 1'b1)
        end
    endtask
    task automatic no_answer();
        begin
            cfg(2'h3, 6'h02, 6'h06, 1'b1, 1'b1, 16'hffff, 8'h48);
            run_slot(who, t0);
            `CHECK(who, 1)
            `CHECK(c_to - s_to, 1)
            `CHECK((t_to - t0 >= 320) && (t_to - t0 <= 326), 1'b1)
            `CHECK(t_rise - t_to <= 2, 1'b1)
            `CHECK(n_got, 8'h00)
            `CHECK(c_done - s_done, 0)
            `CHECK(active_slave, 1'b0)
        end
    endtask
    task automatic too_small();
        begin
            cfg(2'h1, 6'h05, 6'h06, 1'b1, 1'b1, 16'h000a, 8'h02);
            run_slot(who, t0);
            `CHECK(who, 0)
            `CHECK(c_ref - s_ref, 1)
            `CHECK(c_done - s_done, 0)
            `CHECK(active_slave, 1'b1)
        end
    endtask
    task automatic rx_default();
        begin
            cfg(2'h1, 6'h00, 6'h06, 1'b1, 1'b1, 16'h0028, 8'h7f);
            run_slot(who, t0);
            run_slot(who, t1);
            `CHECK(who, 1)
            `CHECK(first, 8'h48)
            `CHECK(n_got, 8'h09)
            `CHECK(c_rxv - s_rxv, 8)
            `CHECK(c_take - s_take, 0)
            `CHECK(early, 8'h00)
            `CHECK(active_slave, 1'b0)
        end
    endtask
    task automatic slow_tx();
        begin
            cfg(2'h2, 6'h01, 6'h1f, 1'b1, 1'b0, 16'h0000, 8'h3f);
            run_slot(who, t0);
            run_slot(who, t1);
            `CHECK(first, 8'h81)
            `CHECK(last, 8'h33)
            `CHECK(c_take - s_take, 1)
            `CHECK(c_done - s_done, 1)
            `CHECK(t_rise - t1 >= 1587, 1'b1)
        end
    endtask
    task automatic bypass();
        begin
            cfg(2'h2, 6'h01, 6'h06, 1'b0, 1'b1, 16'hffff, 8'h3f);
            run_slot(who, t0);
            `CHECK(who, 1)
            `CHECK(c_done - s_done, 1)
            `CHECK(c_to - s_to, 0)
            `CHECK(early != 8'h00, 1'b1)
        end
    endtask

    initial
    begin
        reset_n_i = 1'b0;
        repeat (20) @(posedge clock_i);
        `CHECK({sel_a_n, sel_b_n, sck}, 3'h7)
        reset_n_i <= 1'b1;
        pair_txrx();
        no_answer();
        too_small();
        rx_default();
        slow_tx();
        bypass();
        end_sim();
    end
endmodule

// >>> rtl/spi_busy_map.svh
// constants for the busy-handshake spi master
`ifndef SPI_BUSY_MAP_SVH
`define SPI_BUSY_MAP_SVH
`define CLOCK_MHZ 20
`define SLOT_PERIOD_US 1000
`define SLOT_CYCLES (`SLOT_PERIOD_US * `CLOCK_MHZ)
`define BUSY_TIMEOUT_US 16
`define BUSY_TIMEOUT_CYCLES 9'(`BUSY_TIMEOUT_US * `CLOCK_MHZ)
`define LINK_PERIOD_NS 80
`define NOMINAL_RATE_KBPS 1000
`define SLOWEST_RATE_KBPS 200
`define SCK_HALF_NOMINAL 6'(1000000 / (2 * `NOMINAL_RATE_KBPS * `LINK_PERIOD_NS))
`define SCK_HALF_SLOWEST 6'(1000000 / (2 * `SLOWEST_RATE_KBPS * `LINK_PERIOD_NS))
`define CHAR_LAST_BIT 3'h7
`define COUNT_DEFAULT 6'h08
`define OP_STATUS 2'h0
`define OP_RX 2'h1
`define OP_TX 2'h2
`define OP_TXRX 2'h3
`define CMD_STATUS 8'h00
`define FILL_BYTE 8'h00
`define CMD_OP_MSB 7
`define CMD_OP_LSB 6
`define CMD_CNT_MSB 5
`endif

// >>> rtl/spi_busy_pkg.sv
// types shared by the busy-handshake spi master
package spi_busy_pkg;
    typedef enum logic [2:0] {st_idle, st_select, st_wait_busy, st_xfer, st_finish} ctrl_state_t;
    typedef enum logic {ph_status, ph_data} slot_phase_t;
endpackage

// >>> rtl/spi_master_busy_handshake.sv
// spi master with busy handshake, timeout and 1 ms slot scheduling
// Behaviour
// (RULE_01) select line goes low before any serial clock edge for that slave
// (RULE_02) master drives clock and data out, samples data in on same clock
// (RULE_03) slave must be ready when serial clock starts toggling
// (RULE_04) transfer starts only after busy is seen low
// (RULE_05) one slot starts every 1 ms
// (RULE_06) status-check command learns how many characters slave can move
// (RULE_07) receive, transmit and transmit-receive data commands are supported
// (RULE_08) bit rate nominally 1 Mbps, adjustable down to about 200 kbps
// (RULE_09) characters per slot configurable up to 63, default 8
// (RULE_10) wait for busy low is limited to 16 us
// (RULE_11) on timeout the slave is taken as absent and the slot ends
// (RULE_12) first timing starts at select falling edge, stops at busy low
// (RULE_13) command byte shifts out as soon as busy is seen low
// (RULE_14) busy is timed again before every later character exchange
// (RULE_15) busy synchronisation can be bypassed
// (RULE_16) timeout can be removed so busy held low means always ready
// (RULE_17) command byte: top two bits operation, low six bits count
// (RULE_18) status answer: 01 count slave can send, 00 count it accepts
// (RULE_19) characters are 8 bits, most significant bit first
// (RULE_20) one character at a time with completion after each
// (RULE_21) two select outputs, only one low, target alternates per slot pair
// (RULE_22) select released at normal end and on timeout
// (RULE_23) flags pulse on every timeout and every completed slot
`timescale 1ns/1ns
`include "spi_busy_map.svh"
module spi_master_busy_handshake #(
    parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
    input wire logic clock_i, // system clock, 20 MHz
    input wire logic reset_n_i, // async reset, active low
    input wire logic link_clock_i, // link-side clock
    input wire logic busy_i, // slave busy, low when ready
    input wire logic master_serial_data_in_i, // serial data from slave
    output logic first_slave_select_n_o, // select of slave 0, active low
    output logic second_slave_select_n_o, // select of slave 1, active low
    output logic master_serial_clock_out_o, // serial clock, idles high
    output logic master_serial_data_out_o, // serial data to slave
    input wire logic [1:0] op_mode_i, // data command kind, 00 means tx/rx
    input wire logic [5:0] char_count_i, // characters per slot, 0 means default
    input wire logic [5:0] sck_half_i, // half bit time in link clocks
    input wire logic busy_sync_en_i, // 1 waits for busy low
    input wire logic timeout_en_i, // 1 enforces the busy timeout
    input wire logic [7:0] tx_byte_i, // next character to send
    output logic tx_take_o, // pulse: tx_byte_i was taken
    output logic [7:0] rx_byte_o, // last received character
    output logic rx_valid_o, // pulse: rx_byte_o is new
    output logic [7:0] slave_status_o, // last status answer
    output logic active_slave_o, // slave targeted by current pair
    output logic timeout_o, // pulse: busy timeout
    output logic slot_done_o, // pulse: slot completed normally
    output logic refused_o // pulse: slave capacity too small
);
    spi_busy_pkg::ctrl_state_t state;
    spi_busy_pkg::slot_phase_t phase;
    logic [31:0] slot_cnt;
    logic slot_tick;
    logic [8:0] wait_cnt;
    logic [5:0] byte_idx;
    logic [5:0] last_idx;
    logic [1:0] mode;
    logic [5:0] count;
    logic aborted;
    logic busy_s;
    logic ready;
    logic req_tgl;
    logic ack_s;
    logic [7:0] word_tx;
    logic [5:0] word_half;
    logic [7:0] next_byte;
    logic [5:0] next_half;
    logic fits;
    // link domain
    logic req_l;
    logic ack_tgl;
    logic run;
    logic [7:0] shift;
    logic [7:0] rx_shift;
    logic [7:0] rx_word;
    logic [5:0] half_cnt;
    logic [2:0] bit_cnt;

    sync3_agree #(.WIDTH(1), .INIT(1'b1)) u_busy_sync (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .async_i(busy_i),
        .level_o(busy_s)
    );

    sync3_agree #(.WIDTH(1), .INIT(1'b0)) u_ack_sync (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .async_i(ack_tgl),
        .level_o(ack_s)
    );

    sync3_agree #(.WIDTH(1), .INIT(1'b0)) u_req_sync (
        .clock_i(link_clock_i),
        .reset_n_i(reset_n_i),
        .async_i(req_tgl),
        .level_o(req_l)
    );

    // slot timer
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            slot_cnt <= 32'h0;
        else if (slot_tick)
            slot_cnt <= 32'h0;
        else
            slot_cnt <= slot_cnt + 32'h1;
    end
    assign slot_tick = (slot_cnt == 32'(SLOT_CYCLES - 1)); // RULE_05

    assign ready = !busy_sync_en_i || !busy_s; // RULE_04 RULE_15 RULE_16
    assign last_idx = (phase == spi_busy_pkg::ph_status) ? 6'h01 : count;

    // capacity check on the status answer
    always_comb
    begin
        fits = (rx_word[`CMD_CNT_MSB:0] >= count); // RULE_18
        if (mode == `OP_RX)
            fits = fits && (rx_word[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_RX);
        else if (mode == `OP_TX)
            fits = fits && (rx_word[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_STATUS);
        else
            fits = fits && !rx_word[`CMD_OP_MSB];
    end

    // next character to load
    always_comb
    begin
        if (byte_idx == 6'h00 && phase == spi_busy_pkg::ph_status)
            next_byte = `CMD_STATUS; // RULE_06
        else if (byte_idx == 6'h00)
            next_byte = {mode, count}; // RULE_17 RULE_07
        else if (phase == spi_busy_pkg::ph_data && mode != `OP_RX)
            next_byte = tx_byte_i;
        else
            next_byte = `FILL_BYTE;
        if (sck_half_i == 6'h00 || sck_half_i < `SCK_HALF_NOMINAL)
            next_half = `SCK_HALF_NOMINAL; // RULE_08
        else if (sck_half_i > `SCK_HALF_SLOWEST)
            next_half = `SCK_HALF_SLOWEST;
        else
            next_half = sck_half_i;
    end

    // slot sequencer
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= spi_busy_pkg::st_idle;
            wait_cnt <= 9'h0;
            byte_idx <= 6'h0;
            aborted <= 1'b0;
            req_tgl <= 1'b0;
            word_tx <= 8'h0;
            word_half <= 6'h0;
        end
        else
        begin
            case (state)
                spi_busy_pkg::st_idle:
                begin
                    aborted <= 1'b0;
                    if (slot_tick)
                        state <= spi_busy_pkg::st_select;
                end
                spi_busy_pkg::st_select:
                begin
                    wait_cnt <= 9'h0; // RULE_12
                    byte_idx <= 6'h0;
                    state <= spi_busy_pkg::st_wait_busy;
                end
                spi_busy_pkg::st_wait_busy:
                begin
                    if (ready)
                    begin
                        word_tx <= next_byte; // RULE_13 RULE_14
                        word_half <= next_half;
                        req_tgl <= !req_tgl;
                        state <= spi_busy_pkg::st_xfer;
                    end
                    else if (timeout_en_i && wait_cnt == `BUSY_TIMEOUT_CYCLES - 9'h1)
                    begin
                        aborted <= 1'b1; // RULE_10 RULE_11
                        state <= spi_busy_pkg::st_finish;
                    end
                    else if (timeout_en_i)
                        wait_cnt <= wait_cnt + 9'h1; // RULE_16
                end
                spi_busy_pkg::st_xfer:
                begin
                    if (ack_s == req_tgl) // RULE_20
                    begin
                        wait_cnt <= 9'h0;
                        if (byte_idx == last_idx)
                        begin
                            if (phase == spi_busy_pkg::ph_status && !fits)
                                aborted <= 1'b1;
                            state <= spi_busy_pkg::st_finish;
                        end
                        else
                        begin
                            byte_idx <= byte_idx + 6'h1;
                            state <= spi_busy_pkg::st_wait_busy; // RULE_14
                        end
                    end
                end
                spi_busy_pkg::st_finish:
                    state <= spi_busy_pkg::st_idle;
                default:
                    state <= spi_busy_pkg::st_idle;
            endcase
        end
    end

    // slot phase, target slave and command latch
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            phase <= spi_busy_pkg::ph_status;
            active_slave_o <= 1'b0;
            mode <= `OP_TXRX;
            count <= `COUNT_DEFAULT;
        end
        else if (state == spi_busy_pkg::st_idle && slot_tick
                 && phase == spi_busy_pkg::ph_status)
        begin
            mode <= (op_mode_i == `OP_STATUS) ? `OP_TXRX : op_mode_i;
            count <= (char_count_i == 6'h00) ? `COUNT_DEFAULT : char_count_i; // RULE_09
        end
        else if (state == spi_busy_pkg::st_finish)
        begin
            // any abandoned slot moves on to the other slave
            if (aborted || phase == spi_busy_pkg::ph_data)
            begin
                phase <= spi_busy_pkg::ph_status;
                active_slave_o <= !active_slave_o; // RULE_21
            end
            else
                phase <= spi_busy_pkg::ph_data;
        end
    end

    // select lines: low only from select through the end of the slot
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            first_slave_select_n_o <= 1'b1;
            second_slave_select_n_o <= 1'b1;
        end
        else if (state == spi_busy_pkg::st_idle && slot_tick)
        begin
            first_slave_select_n_o <= active_slave_o; // RULE_01 RULE_21
            second_slave_select_n_o <= !active_slave_o;
        end
        else if (state == spi_busy_pkg::st_finish)
        begin
            first_slave_select_n_o <= 1'b1; // RULE_22
            second_slave_select_n_o <= 1'b1;
        end
    end

    // event pulses and received data
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            timeout_o <= 1'b0;
            slot_done_o <= 1'b0;
            refused_o <= 1'b0;
            tx_take_o <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_byte_o <= 8'h0;
            slave_status_o <= 8'h0;
        end
        else
        begin
            timeout_o <= state == spi_busy_pkg::st_wait_busy && !ready && timeout_en_i
                && wait_cnt == `BUSY_TIMEOUT_CYCLES - 9'h1; // RULE_23
            slot_done_o <= state == spi_busy_pkg::st_finish && !aborted; // RULE_23
            refused_o <= state == spi_busy_pkg::st_xfer && ack_s == req_tgl && !fits
                && phase == spi_busy_pkg::ph_status && byte_idx == last_idx;
            tx_take_o <= state == spi_busy_pkg::st_wait_busy && ready && byte_idx != 6'h00
                && phase == spi_busy_pkg::ph_data && mode != `OP_RX;
            rx_valid_o <= 1'b0;
            if (state == spi_busy_pkg::st_xfer && ack_s == req_tgl && byte_idx != 6'h00)
            begin
                if (phase == spi_busy_pkg::ph_status)
                    slave_status_o <= rx_word;
                else if (mode != `OP_TX)
                begin
                    rx_byte_o <= rx_word;
                    rx_valid_o <= 1'b1;
                end
            end
        end
    end

    // link side: one 8-bit character per request, clock idles high
    always_ff @(posedge link_clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            run <= 1'b0;
            ack_tgl <= 1'b0;
            shift <= 8'h0;
            rx_shift <= 8'h0;
            rx_word <= 8'h0;
            half_cnt <= 6'h0;
            bit_cnt <= 3'h0;
            master_serial_clock_out_o <= 1'b1;
            master_serial_data_out_o <= 1'b1;
        end
        else if (!run)
        begin
            if (req_l != ack_tgl)
            begin
                run <= 1'b1;
                shift <= word_tx;
                half_cnt <= 6'h0;
                bit_cnt <= 3'h0;
            end
        end
        else if (half_cnt != word_half - 6'h1)
            half_cnt <= half_cnt + 6'h1;
        else
        begin
            half_cnt <= 6'h0;
            master_serial_clock_out_o <= !master_serial_clock_out_o; // RULE_02
            if (master_serial_clock_out_o)
                master_serial_data_out_o <= shift[`CHAR_LAST_BIT]; // RULE_19
            else
            begin
                rx_shift <= {rx_shift[6:0], master_serial_data_in_i}; // RULE_02
                shift <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == `CHAR_LAST_BIT)
                begin
                    run <= 1'b0;
                    rx_word <= {rx_shift[6:0], master_serial_data_in_i};
                    ack_tgl <= !ack_tgl; // RULE_20
                end
            end
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    a_select_exclusive: assert property ( // RULE_21
        first_slave_select_n_o || second_slave_select_n_o)
        else $error("both slave selects low");

    a_timeout_bound: assert property ( // RULE_10
        state == spi_busy_pkg::st_wait_busy |-> wait_cnt < `BUSY_TIMEOUT_CYCLES)
        else $error("busy wait ran past the timeout");

    a_timeout_deselect: assert property ( // RULE_11
        timeout_o |=> first_slave_select_n_o && second_slave_select_n_o
        && state == spi_busy_pkg::st_idle)
        else $error("slot not ended after busy timeout");

    a_busy_gate: assert property ( // RULE_04
        $changed(req_tgl) |-> $past(ready) && $past(state) == spi_busy_pkg::st_wait_busy)
        else $error("character started without busy low");

    a_busy_start: assert property ( // RULE_13
        state == spi_busy_pkg::st_wait_busy && ready |=> $changed(req_tgl))
        else $error("busy low did not start the character");

    a_slot_period: assert property ( // RULE_05
        slot_tick |=> !slot_tick [*8])
        else $error("slot ticks too close");

    a_done_release: assert property ( // RULE_22
        slot_done_o |-> first_slave_select_n_o && second_slave_select_n_o)
        else $error("select still low after slot end");

    a_sck_under_select: assert property ( // RULE_01
        @(posedge link_clock_i) disable iff (!reset_n_i)
        !master_serial_clock_out_o |-> !(first_slave_select_n_o && second_slave_select_n_o))
        else $error("serial clock active with no slave selected");

    a_bit_rate_range: assert property ( // RULE_08
        @(posedge link_clock_i) disable iff (!reset_n_i)
        run |-> word_half >= `SCK_HALF_NOMINAL && word_half <= `SCK_HALF_SLOWEST)
        else $error("serial clock half period out of range");

    c_timeout: cover property (timeout_o);
    c_slot_done_data: cover property (slot_done_o && phase == spi_busy_pkg::ph_status);
    c_refused: cover property (refused_o);
    c_rx_char: cover property (rx_valid_o);
endmodule

// >>> rtl/sync3_agree.sv
// three-stage synchroniser whose output follows once stages two and three agree
`timescale 1ns/1ns
module sync3_agree #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock_i, // destination clock
    input wire logic reset_n_i, // async reset, active low
    input wire logic [WIDTH-1:0] async_i, // foreign-domain level
    output logic [WIDTH-1:0] level_o // settled level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
        end
        else
        begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a value counts only once it has held for two samples
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            level_o <= INIT;
        else if (stage2 == stage3)
            level_o <= stage3;
    end
endmodule
